/* core/sbsr_pkg.sv */
package sbsr_pkg;
    // status byte bit positions
    localparam int SB_OPERATION_SUMMARY = 7;
    localparam int SB_RQS = 6;
    localparam int SB_ESB = 5;
    localparam int SB_MAV = 4;
    localparam int SB_QUESTIONABLE_SUMMARY = 3;
    localparam int SB_ERR = 2;
    localparam int SB_RSV = 1;
    localparam int SB_RDY = 0;
    localparam logic [7:0] SB_RSV_MASK = 8'h02;
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [7:0] EVT_RESET = 8'h00;
    localparam logic [7:0] ESR_PON = 8'h80;
    localparam logic [7:0] ESR_RQC_MASK = 8'h02;
    // subsystem registers are 16 bits, bit 15 always zero
    localparam int SUB_W = 16;
    localparam logic [15:0] SUB_MASK = 16'h7fff;
    // error queue
    localparam int EQ_DEPTH = 20;
    localparam int EQ_AW = 5;
    localparam int EQ_CW = 16;
    localparam logic [EQ_AW-1:0] EQ_LAST = 5'h13;
    localparam logic [EQ_CW-1:0] EQ_NO_ERROR = 16'h0000;

    typedef struct packed {
        logic valid;
        logic [EQ_CW-1:0] code;
    } sbsr_err_t;

    typedef struct packed {
        logic [7:0] stb;
        logic [7:0] poll;
        logic srq;
    } sbsr_status_t;
endpackage

/* core/sbsr_err_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module sbsr_err_queue (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // push side
    input wire sbsr_pkg::sbsr_err_t push,
    // pop side
    input wire logic pop,
    output sbsr_pkg::sbsr_err_t head,
    output logic [sbsr_pkg::EQ_AW-1:0] count,
    output logic overflow
);
    logic [sbsr_pkg::EQ_CW-1:0] mem [sbsr_pkg::EQ_DEPTH];
    logic [sbsr_pkg::EQ_AW-1:0] rd, wr, next_rd, next_wr, next_count;
    logic next_overflow;
    logic do_push, do_pop;

    function automatic logic [sbsr_pkg::EQ_AW-1:0] bump(input logic [sbsr_pkg::EQ_AW-1:0] p);
        bump = (p == sbsr_pkg::EQ_LAST) ? '0 : p + 5'h01;
    endfunction

    always_comb begin
        do_pop = pop && (count != '0);
        // a full queue stops accumulating; a same-cycle pop makes room
        do_push = push.valid && ((count != 5'(sbsr_pkg::EQ_DEPTH)) || do_pop);
        next_rd = do_pop ? bump(rd) : rd;
        next_wr = do_push ? bump(wr) : wr;
        next_count = count + 5'(do_push) - 5'(do_pop);
        next_overflow = push.valid && !do_push;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd <= '0;
            wr <= '0;
            count <= '0;
            overflow <= 1'b0;
        end else begin
            rd <= next_rd;
            wr <= next_wr;
            count <= next_count;
            overflow <= next_overflow;
        end
    end

    // storage has no reset; only valid slots are ever read
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr] <= push.code;
        end
    end

    // empty queue answers code zero
    assign head.valid = (count != '0);
    assign head.code = (count != '0) ? mem[rd] : sbsr_pkg::EQ_NO_ERROR;
endmodule
`default_nettype wire

/* core/sbsr_status_byte.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - two 16-bit summary event registers on top
// - bit 15 of subsystem registers reads zero
// - request line only on bus port
// - each remote error appended to queue unless full
// - serial port replies error marker on error
// - error read returns oldest, removes it
// - queue holds up to twenty entries
// - empty queue read returns code zero
// - status byte layout, eight bits
// - poll shows RQS, query shows MSS
// - enable mask per bit, bit 6 ignored
// - mask 14 hex requests on MAV or error
// - bit 7 follows operation summary
// - RQS set on request, cleared by poll
// - MSS read-only, clears with its causes
// - ESB from enabled standard event bits
// - MAV while reply waits in output queue
// - bit 3 follows questionable summary
// - bit 2 while error queue not empty
// - bit 0 from enabled transducer ready bits
// - standard event register eight-bit layout
// - transducer ready register eight-bit layout
module sbsr_status_byte (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // subsystem top-layer event registers
    input wire logic [sbsr_pkg::SUB_W-1:0] operation_event,
    input wire logic [sbsr_pkg::SUB_W-1:0] questionable_event,
    input wire logic [sbsr_pkg::SUB_W-1:0] operation_enable,
    input wire logic [sbsr_pkg::SUB_W-1:0] questionable_enable,
    // standard event sources, one-cycle pulses
    input wire logic [7:0] std_event_set,
    input wire logic std_event_read,
    input wire logic [7:0] std_event_enable,
    // transducer ready sources, one-cycle pulses
    input wire logic [7:0] ready_event_set,
    input wire logic ready_event_read,
    input wire logic [7:0] ready_event_enable,
    // output queue and port selection
    input wire logic reply_waiting,
    input wire logic serial_port_active,
    // error queue access
    input wire logic error_push,
    input wire logic [sbsr_pkg::EQ_CW-1:0] error_code,
    input wire logic error_read,
    // service request enable mask
    input wire logic sre_write,
    input wire logic [7:0] sre_data,
    // serial poll strobe from the bus interface
    input wire logic serial_poll,
    // results
    output logic [sbsr_pkg::SUB_W-1:0] operation_status,
    output logic [sbsr_pkg::SUB_W-1:0] questionable_status,
    output logic operation_summary,
    output logic questionable_summary,
    output logic [7:0] std_event_status,
    output logic [7:0] ready_event_status,
    output logic [7:0] summary_status_byte,
    output logic [7:0] poll_status_byte,
    output logic [7:0] sre_mask,
    output logic service_request,
    output logic serial_error_reply,
    output logic error_valid,
    output logic [sbsr_pkg::EQ_CW-1:0] error_reply_code,
    output logic [sbsr_pkg::EQ_AW-1:0] error_count,
    output logic error_overflow
);
    sbsr_pkg::sbsr_err_t eq_push, eq_head;
    logic [sbsr_pkg::EQ_AW-1:0] eq_count;
    logic eq_ovf;

    // a served request keeps RQS clear until its causes clear or the serial port takes over
    typedef enum {
        REQ_IDLE,
        REQ_RAISED,
        REQ_SERVED
    } sbsr_req_state_t;

    logic [7:0] esr, next_esr, rdy, next_rdy, sre, next_sre;
    sbsr_req_state_t req_state, next_req_state;
    logic rqs, req_line;
    logic [7:0] sb_core;
    logic mss;
    sbsr_pkg::sbsr_status_t st, next_st;
    logic [sbsr_pkg::SUB_W-1:0] next_operation_summary, next_questionable_summary;
    logic next_osum, next_qsum, next_serr, next_evalid;
    logic [sbsr_pkg::EQ_CW-1:0] next_ecode;
    logic [sbsr_pkg::EQ_AW-1:0] next_ecount;
    logic next_eovf;
    logic reply_q1, reply_q2;

    // bit 15 kept clear: some hosts read it as a sign
    function automatic logic [sbsr_pkg::SUB_W-1:0] strip_sign(
            input logic [sbsr_pkg::SUB_W-1:0] v);
        strip_sign = v & sbsr_pkg::SUB_MASK;
    endfunction

    function automatic logic any_enabled(input logic [sbsr_pkg::SUB_W-1:0] evt,
            input logic [sbsr_pkg::SUB_W-1:0] ena);
        any_enabled = |(evt & ena);
    endfunction

    // set beats a read that clears, so no event is lost
    function automatic logic [7:0] sticky(input logic [7:0] cur, input logic clr,
            input logic [7:0] evt_set);
        sticky = (clr ? 8'h00 : cur) | evt_set;
    endfunction

    function automatic logic [7:0] at_rqs(input logic flag);
        at_rqs = {7'h00, flag} << sbsr_pkg::SB_RQS;
    endfunction

    assign eq_push.valid = error_push;
    assign eq_push.code = error_code;

    sbsr_err_queue u_eq (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .push(eq_push),
        .pop(error_read),
        .head(eq_head),
        .count(eq_count),
        .overflow(eq_ovf)
    );

    // reply presence can come from another clock; pass two flops
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reply_q1 <= 1'b0;
            reply_q2 <= 1'b0;
        end else begin
            reply_q1 <= reply_waiting;
            reply_q2 <= reply_q1;
        end
    end

    // subsystem top layer
    always_comb begin
        next_operation_summary = strip_sign(operation_event);
        next_questionable_summary = strip_sign(questionable_event);
        next_osum = any_enabled(next_operation_summary, operation_enable);
        next_qsum = any_enabled(next_questionable_summary, questionable_enable);
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            operation_status <= '0;
            questionable_status <= '0;
            operation_summary <= 1'b0;
            questionable_summary <= 1'b0;
        end else begin
            operation_status <= next_operation_summary;
            questionable_status <= next_questionable_summary;
            operation_summary <= next_osum;
            questionable_summary <= next_qsum;
        end
    end

    // sticky event registers and enable mask
    always_comb begin
        next_esr = sticky(esr, std_event_read, std_event_set) & ~sbsr_pkg::ESR_RQC_MASK;
        next_rdy = sticky(rdy, ready_event_read, ready_event_set);
        next_sre = sre_write ? sre_data : sre;
        next_sre[sbsr_pkg::SB_RQS] = 1'b0;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            esr <= sbsr_pkg::ESR_PON;
            rdy <= sbsr_pkg::EVT_RESET;
            sre <= sbsr_pkg::SRE_RESET;
        end else begin
            esr <= next_esr;
            rdy <= next_rdy;
            sre <= next_sre;
        end
    end

    // status byte core and master summary
    always_comb begin
        sb_core = 8'h00;
        sb_core[sbsr_pkg::SB_OPERATION_SUMMARY] = operation_summary;
        sb_core[sbsr_pkg::SB_ESB] = any_enabled(16'(esr), 16'(std_event_enable));
        sb_core[sbsr_pkg::SB_MAV] = reply_q2;
        sb_core[sbsr_pkg::SB_QUESTIONABLE_SUMMARY] = questionable_summary;
        sb_core[sbsr_pkg::SB_ERR] = (eq_count != '0);
        sb_core[sbsr_pkg::SB_RDY] = any_enabled(16'(rdy), 16'(ready_event_enable));
        sb_core = sb_core & ~sbsr_pkg::SB_RSV_MASK;
        // mask bit 6 is held zero, so 8'h14 fires on MAV or error
        mss = any_enabled(16'(sb_core), 16'(sre));
        // request line only on the bus port
        req_line = mss && !serial_port_active;
    end

    // requested-service tracking
    always_comb begin
        next_req_state = req_state;
        case (req_state)
            REQ_IDLE: begin
                // a poll in the same cycle wins; the request rises a cycle later
                if (req_line && !serial_poll) begin
                    next_req_state = REQ_RAISED;
                end
            end
            REQ_RAISED: begin
                // no requested-service bit while the serial port is in use
                if (serial_poll || serial_port_active) begin
                    next_req_state = REQ_SERVED;
                end
            end
            REQ_SERVED: begin
                if (!req_line) begin
                    next_req_state = REQ_IDLE;
                end
            end
            default: begin
                next_req_state = REQ_IDLE;
            end
        endcase
        rqs = (next_req_state == REQ_RAISED);
        next_st.stb = sb_core | at_rqs(mss);
        next_st.poll = sb_core | at_rqs(rqs);
        next_st.srq = req_line;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            req_state <= REQ_IDLE;
            st <= '0;
        end else begin
            req_state <= next_req_state;
            st <= next_st;
        end
    end

    // error queue replies
    always_comb begin
        // serial host reads each reply before sending more, so one marker suffices
        next_serr = serial_port_active && error_push;
        next_evalid = eq_head.valid;
        next_ecode = eq_head.code;
        next_ecount = eq_count;
        next_eovf = eq_ovf;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            serial_error_reply <= 1'b0;
            error_valid <= 1'b0;
            error_reply_code <= sbsr_pkg::EQ_NO_ERROR;
            error_count <= '0;
            error_overflow <= 1'b0;
        end else begin
            serial_error_reply <= next_serr;
            error_valid <= next_evalid;
            error_reply_code <= next_ecode;
            error_count <= next_ecount;
            error_overflow <= next_eovf;
        end
    end

    assign std_event_status = esr;
    assign ready_event_status = rdy;
    assign sre_mask = sre;
    assign summary_status_byte = st.stb;
    assign poll_status_byte = st.poll;
    assign service_request = st.srq;
endmodule
`default_nettype wire

/* dv/sbsr_props_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sbsr_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // watched inputs
    input wire logic serial_port_active,
    input wire logic error_push,
    input wire logic serial_poll,
    // watched outputs
    input wire logic [sbsr_pkg::SUB_W-1:0] operation_status,
    input wire logic [sbsr_pkg::SUB_W-1:0] questionable_status,
    input wire logic [7:0] summary_status_byte,
    input wire logic [7:0] poll_status_byte,
    input wire logic [7:0] sre_mask,
    input wire logic service_request,
    input wire logic serial_error_reply,
    input wire logic error_valid,
    input wire logic [sbsr_pkg::EQ_CW-1:0] error_reply_code,
    input wire logic [sbsr_pkg::EQ_AW-1:0] error_count,
    input wire logic error_overflow
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // windows of three cycles let registered stages settle
    logic [7:0] armed;
    assign armed = summary_status_byte & sre_mask & 8'hbf;
    AST_BIT15: assert property (!operation_status[15] && !questionable_status[15])
        else $error("bit 15 set in subsystem status");
    AST_UNUSED_BIT: assert property (!summary_status_byte[1])
        else $error("status byte bit 1 set");
    AST_POLL_SAME: assert property (((summary_status_byte ^ poll_status_byte) & 8'hbf) == 8'h00)
        else $error("poll byte differs outside bit 6");
    AST_MASK6: assert property (!sre_mask[6])
        else $error("enable mask bit 6 set");
    AST_MSS_SET: assert property ((armed != 8'h00) [*3] |-> summary_status_byte[6])
        else $error("summary bit low with enabled cause");
    AST_MSS_CLR: assert property ((armed == 8'h00) [*3] |-> !summary_status_byte[6])
        else $error("summary bit high without cause");
    AST_SERIAL_QUIET: assert property (serial_port_active [*3] |-> !service_request)
        else $error("request line on serial port");
    AST_RQS_SET: assert property ($rose(service_request) |-> ##[0:2] poll_status_byte[6])
        else $error("requested service bit missing");
    AST_RQS_CLR: assert property (serial_poll |-> ##[1:2] !poll_status_byte[6])
        else $error("poll did not clear requested service");
    AST_ERR_BIT: assert property ((error_count != 5'h00) [*3] |-> summary_status_byte[2])
        else $error("error bit low with queue entries");
    AST_ERR_MAX: assert property (error_overflow |-> error_count == 5'h14)
        else $error("overflow below twenty entries");
    AST_EMPTY: assert property (!error_valid |-> error_reply_code == 16'h0000)
        else $error("empty queue code not zero");
    AST_MARKER: assert property (error_push && serial_port_active |-> ##[1:3] serial_error_reply)
        else $error("serial error marker missing");
    cover property (service_request);
    cover property (error_overflow);
    cover property (serial_poll ##1 !poll_status_byte[6]);
endmodule
bind sbsr_status_byte sbsr_props u_props (.clk_sys, .sys_rst, .serial_port_active, .error_push,
    .serial_poll, .operation_status, .questionable_status, .summary_status_byte,
    .poll_status_byte, .sre_mask, .service_request, .serial_error_reply, .error_valid,
    .error_reply_code, .error_count, .error_overflow);
`default_nettype wire

/* dv/sbsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sbsr_host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // bus side
    input wire logic service_request,
    input wire logic poll_en,
    output logic serial_poll
);
    logic [1:0] wait_cnt;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wait_cnt <= 2'h0;
            serial_poll <= 1'b0;
        end else begin
            // a slow host: polls only on the bus, a few cycles after the request
            serial_poll <= poll_en && service_request && wait_cnt == 2'h3;
            wait_cnt <= (poll_en && service_request && !serial_poll) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

/* dv/tb_status_byte_service_request.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_status_byte_service_request;
    logic clk_sys, sys_rst, std_event_read, ready_event_read, reply_waiting, serial_port_active;
    logic error_push, error_read, sre_write, serial_poll, poll_en, service_request;
    logic serial_error_reply, error_valid, error_overflow, operation_summary, questionable_summary;
    logic [15:0] operation_event, questionable_event, operation_enable, questionable_enable;
    logic [15:0] operation_status, questionable_status, error_code, error_reply_code;
    logic [7:0] std_event_set, std_event_enable, ready_event_set, ready_event_enable, sre_data;
    logic [7:0] std_event_status, ready_event_status, summary_status_byte, poll_status_byte;
    logic [7:0] sre_mask;
    logic [4:0] error_count;
    int bad_count, checks, cycles, replies, ovf_seen;
    sbsr_status_byte dut (.*);
    sbsr_host_model host (.clk_sys, .sys_rst, .service_request, .poll_en, .serial_poll);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        replies += serial_error_reply;
        ovf_seen += error_overflow;
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // bounded wait, since summary bits settle over several stages
    task automatic wait_byte(input logic [7:0] m, input logic [7:0] v);
        for (int i = 0; i < 12 && (summary_status_byte & m) !== v; i++) tick(1);
        chk(16'(summary_status_byte & m), 16'(v));
    endtask
    initial begin
        {sys_rst, poll_en, std_event_read, ready_event_read, reply_waiting} = 5'h10;
        {serial_port_active, error_push, error_read, sre_write} = 4'h0;
        {operation_event, questionable_event, operation_enable, questionable_enable} = '0;
        {std_event_set, std_event_enable, ready_event_set, ready_event_enable, sre_data} = '0;
        error_code = 16'h0000;
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        chk(std_event_status, 16'h0080);
        chk(summary_status_byte, 16'h0000);
        $display("test reset done");
        operation_event <= 16'h8000;
        operation_enable <= 16'h8001;
        questionable_event <= 16'h8004;
        questionable_enable <= 16'h8000;
        tick(6);
        chk(operation_status, 16'h0000);
        chk(questionable_status, 16'h0004);
        chk(16'(summary_status_byte & 8'h88), 16'h0000);
        operation_event <= 16'h0001;
        questionable_enable <= 16'h0004;
        wait_byte(8'h88, 8'h88);
        chk(16'({operation_summary, questionable_summary}), 16'h0003);
        operation_event <= 16'h0000;
        wait_byte(8'h88, 8'h08);
        questionable_event <= 16'h0000;
        wait_byte(8'h88, 8'h00);
        std_event_enable <= 8'h20;
        ready_event_enable <= 8'h10;
        std_event_set <= 8'h24;
        ready_event_set <= 8'h11;
        tick(1);
        {std_event_set, ready_event_set} <= 16'h0000;
        wait_byte(8'h21, 8'h21);
        chk(ready_event_status, 16'h0011);
        {std_event_read, ready_event_read} <= 2'h3;
        tick(1);
        {std_event_read, ready_event_read} <= 2'h0;
        wait_byte(8'h21, 8'h00);
        chk(std_event_status, 16'h0000);
        $display("test summaries done");
        sre_write <= 1'b1;
        sre_data <= 8'h54;
        tick(1);
        sre_write <= 1'b0;
        reply_waiting <= 1'b1;
        wait_byte(8'hff, 8'h50);
        chk(sre_mask, 16'h0014);
        tick(3);
        chk(service_request, 16'h0001);
        chk(poll_status_byte, 16'h0050);
        poll_en <= 1'b1;
        tick(10);
        poll_en <= 1'b0;
        chk(poll_status_byte, 16'h0010);
        chk(summary_status_byte, 16'h0050);
        serial_port_active <= 1'b1;
        tick(4);
        chk(service_request, 16'h0000);
        reply_waiting <= 1'b0;
        wait_byte(8'h50, 8'h00);
        $display("test request done");
        for (int i = 1; i <= 21; i++) begin
            if (i == 21)
                serial_port_active <= 1'b0;
            error_push <= 1'b1;
            error_code <= 16'(i);
            tick(1);
        end
        error_push <= 1'b0;
        tick(4);
        chk(error_count, 16'h0014);
        chk(16'(ovf_seen), 16'h0001);
        chk(16'(replies), 16'h0014);
        wait_byte(8'h04, 8'h04);
        chk(service_request, 16'h0001);
        for (int i = 1; i <= 21; i++) begin
            chk(error_reply_code, 16'(i % 21));
            error_read <= 1'b1;
            tick(1);
            error_read <= 1'b0;
            tick(2);
        end
        chk(error_valid, 16'h0000);
        wait_byte(8'h04, 8'h00);
        $display("test error queue done");
        test_done();
    end
endmodule
`default_nettype wire
